// File: rtl/iopr_pkg.sv
// Package for the general-purpose port block: widths, reset values, carriers.
// Assumes a single core clock domain; no software-visible register map.
package iopr_pkg;

  localparam int WIDE_W = 8;
  localparam int NARROW_W = 4;
  localparam int RESET_PIN_IDX = 3;

  // Minimum low time on the reset pin, in ns, and its cycle count at 250 MHz
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_MIN_PULSE_NS = 2500;
  localparam int RST_MIN_PULSE_CYC =
      (RST_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W = 10;

  // Values held by the port controls after reset
  localparam logic [7:0] WIDE_DIR_RST = 8'h00;
  localparam logic [7:0] WIDE_OUT_RST = 8'h00;
  localparam logic [7:0] WIDE_PU_RST = 8'h00;
  localparam logic [3:0] NARROW_DIR_RST = 4'h0;
  localparam logic [3:0] NARROW_OUT_RST = 4'h0;
  localparam logic [3:0] NARROW_PU_RST = 4'h0;

  // Port control from the core: direction, output data, pull-up select
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] dout;
    logic [7:0] pull;
  } iopr_wide_ctl_type;

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] dout;
    logic [3:0] pull;
  } iopr_narrow_ctl_type;

  // Alternate function override for the wide port
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] dir;
    logic [7:0] dout;
  } iopr_alt_type;

  // Pad drive for each port: output level, enable, pull-up; only the narrow port adds a weak-drive flag
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull;
  } iopr_wide_pad_type;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
    logic [3:0] pull;
    logic weak3;
  } iopr_narrow_pad_type;

endpackage : iopr_pkg

// File: rtl/iopr_pin_cell.sv
// One port pin cell: registered drive, enable and pull-up select.
// Assumes the port reset request arrives as a synchronous level.
`timescale 1ns/1ps
module iopr_pin_cell #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Tristate request
  input wire logic i_hiz,
  // Control
  input wire logic [W-1:0] i_dir,
  input wire logic [W-1:0] i_dout,
  input wire logic [W-1:0] i_pull,
  // Pad side
  output logic [W-1:0] o_pad_out,
  output logic [W-1:0] o_pad_oe,
  output logic [W-1:0] o_pad_pu
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_hiz) begin
          o_pad_out[g] <= 1'b0;
          o_pad_oe[g] <= 1'b0;
          o_pad_pu[g] <= 1'b0;
        end else begin
          o_pad_out[g] <= i_dout[g];
          o_pad_oe[g] <= i_dir[g];
          // Pull-up only on an input pin
          o_pad_pu[g] <= i_pull[g] & ~i_dir[g];
        end
      end
    end
  endgenerate

endmodule : iopr_pin_cell

// File: rtl/iopr_top.sv
// Top of the general-purpose port block: wide and narrow ports with the
// shared reset pin. Assumes pad inputs are synchronous to the core clock
// and the fuse level is stable; pads resolve oe/out/pu into the wire.
`timescale 1ns/1ps
// How it works
// - The narrow port has four pins, each input or output with its own pull-up select.
// - The wide port has eight pins, each input or output with its own pull-up select.
// - Narrow bit three is the reset input unless the disable fuse reads zero.
// - Any reset puts every narrow-port pin in high impedance.
// - Any reset puts every wide-port pin in high impedance.
// - A low on the enabled reset pin lasting at least the minimum pulse raises a reset.
// - With reset disabled, narrow bit three is a port pin with weak drive only.
// - Wide-port pins can be taken over by alternate functions.
module iopr_top #(
  parameter int WIDE_W = iopr_pkg::WIDE_W,
  parameter int NARROW_W = iopr_pkg::NARROW_W,
  parameter int MIN_PULSE_CYC = iopr_pkg::RST_MIN_PULSE_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Configuration fuse, zero frees the reset pin
  input wire logic i_reset_pin_disable_fuse,
  // Core side controls
  input wire iopr_pkg::iopr_wide_ctl_type i_wide_ctl,
  input wire iopr_pkg::iopr_narrow_ctl_type i_narrow_ctl,
  input wire iopr_pkg::iopr_alt_type i_wide_alt,
  // Pad inputs
  input wire logic [7:0] i_wide_pad,
  input wire logic [3:0] i_narrow_pad,
  // Pad drive
  output iopr_pkg::iopr_wide_pad_type o_wide_pad,
  output iopr_pkg::iopr_narrow_pad_type o_narrow_pad,
  // Pin readback to the core
  output logic [7:0] o_wide_in,
  output logic [3:0] o_narrow_in,
  // Reset request from the pin
  output logic o_ext_reset
);

  logic rst_pin_en;
  logic [iopr_pkg::RST_CNT_W-1:0] low_cnt_q;
  logic [7:0] wide_dir;
  logic [7:0] wide_dout;
  logic [3:0] nar_dir;
  logic [3:0] nar_dout;
  logic [3:0] nar_pull;
  logic hiz;

  // Fuse reads one by default: pin is reset
  assign rst_pin_en = i_reset_pin_disable_fuse;

  // Count the low time on the reset pin; short glitches are dropped
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !rst_pin_en || i_narrow_pad[iopr_pkg::RESET_PIN_IDX]) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q < iopr_pkg::RST_CNT_W'(MIN_PULSE_CYC)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_ext_reset <= 1'b0;
    end else begin
      o_ext_reset <= rst_pin_en && !i_narrow_pad[iopr_pkg::RESET_PIN_IDX] &&
          low_cnt_q >= iopr_pkg::RST_CNT_W'(MIN_PULSE_CYC - 1);
    end
  end

  // Pin reset also tristates the ports
  assign hiz = o_ext_reset;

  // Alternate functions override the port bits
  assign wide_dir = (i_wide_alt.en & i_wide_alt.dir) |
      (~i_wide_alt.en & i_wide_ctl.dir);
  assign wide_dout = (i_wide_alt.en & i_wide_alt.dout) |
      (~i_wide_alt.en & i_wide_ctl.dout);

  // Bit three takes no port control while it serves as reset
  always_comb begin
    nar_dir = i_narrow_ctl.dir;
    nar_dout = i_narrow_ctl.dout;
    nar_pull = i_narrow_ctl.pull;
    if (rst_pin_en) begin
      nar_dir[iopr_pkg::RESET_PIN_IDX] = 1'b0;
      nar_dout[iopr_pkg::RESET_PIN_IDX] = 1'b0;
      // Reset pin has its pull-up forced on so it idles high; any reset clears it in the pin cell
      nar_pull[iopr_pkg::RESET_PIN_IDX] = 1'b1;
    end
  end

  iopr_pin_cell #(.W(8)) u_wide (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_hiz(hiz),
    .i_dir(wide_dir),
    .i_dout(wide_dout),
    .i_pull(i_wide_ctl.pull),
    .o_pad_out(o_wide_pad.dout),
    .o_pad_oe(o_wide_pad.oe),
    .o_pad_pu(o_wide_pad.pull)
  );

  iopr_pin_cell #(.W(4)) u_narrow (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_hiz(hiz),
    .i_dir(nar_dir),
    .i_dout(nar_dout),
    .i_pull(nar_pull),
    .o_pad_out(o_narrow_pad.dout),
    .o_pad_oe(o_narrow_pad.oe),
    .o_pad_pu(o_narrow_pad.pull)
  );

  // Weak drive marker for the shared pin when it is a port pin
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_narrow_pad.weak3 <= 1'b0;
    end else begin
      o_narrow_pad.weak3 <= !rst_pin_en;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_wide_in <= '0;
      o_narrow_in <= '0;
    end else begin
      o_wide_in <= i_wide_pad;
      o_narrow_in <= i_narrow_pad;
    end
  end

  property p_wide_hiz;
    @(posedge i_core_clk) (i_sys_rst || hiz) |=> (o_wide_pad.oe == 8'h00);
  endproperty
  a_wide_hiz: assert property (p_wide_hiz)
    else $error("wide port driven after reset");

  property p_nar_hiz;
    @(posedge i_core_clk) (i_sys_rst || hiz) |=> (o_narrow_pad.oe == 4'h0);
  endproperty
  a_nar_hiz: assert property (p_nar_hiz)
    else $error("narrow port driven during reset");

  property p_rst_pin_in;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      rst_pin_en |=> !o_narrow_pad.oe[3];
  endproperty
  a_rst_pin_in: assert property (p_rst_pin_in)
    else $error("reset pin driven as output");

  property p_short_low;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (low_cnt_q == '0) |=> !o_ext_reset;
  endproperty
  a_short_low: assert property (p_short_low)
    else $error("reset raised on a short pulse");

  property p_weak;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !rst_pin_en ##1 !rst_pin_en |-> o_narrow_pad.weak3;
  endproperty
  a_weak: assert property (p_weak)
    else $error("freed reset pin not marked weak");

  property p_dir;
    @(posedge i_core_clk) disable iff (i_sys_rst || hiz)
      (!i_wide_alt.en[0] && i_wide_ctl.dir[0]) |=> o_wide_pad.oe[0];
  endproperty
  a_dir: assert property (p_dir)
    else $error("output pin not driven");

  property p_alt;
    @(posedge i_core_clk) disable iff (i_sys_rst || hiz)
      (i_wide_alt.en[1] && i_wide_alt.dir[1]) |=>
        (o_wide_pad.oe[1] && o_wide_pad.dout[1] == $past(i_wide_alt.dout[1]));
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate function not routed");

  property p_pull;
    @(posedge i_core_clk) disable iff (i_sys_rst || hiz)
      (i_narrow_ctl.pull[0] && !i_narrow_ctl.dir[0]) |=> o_narrow_pad.pull[0];
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up not applied");

endmodule : iopr_top

// File: sim/iopr_board.sv
// Board model on the pin side: resolves each pin from drive, pull and load.
// Assumes the bench owns the external drivers; contention is not modelled.
`timescale 1ns/1ps
module iopr_board (
  // Clock
  input wire logic i_core_clk,
  // Pad drive from the block
  input wire iopr_pkg::iopr_wide_pad_type i_wide_pad,
  input wire iopr_pkg::iopr_narrow_pad_type i_narrow_pad,
  // External drivers
  input wire logic [7:0] i_wide_ext,
  input wire logic [7:0] i_wide_ext_en,
  input wire logic [3:0] i_narrow_ext,
  input wire logic [3:0] i_narrow_ext_en,
  // Resolved pin levels
  output logic [7:0] o_wide_wire,
  output logic [3:0] o_narrow_wire
);
  logic [11:0] last_q = 12'h000;
  // A floating pin toggles so a stale level never reads as valid
  function automatic logic res(logic oe, logic d, logic en, logic x,
                               logic pu, logic last);
    return oe ? d : en ? x : pu ? 1'b1 : ~last;
  endfunction : res
  always_ff @(posedge i_core_clk) begin
    // An unknown level settles to zero so the float toggle starts clean
    for (int i = 0; i < 8; i++) begin
      last_q[i] <= (o_wide_wire[i] === 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      last_q[8+i] <= (o_narrow_wire[i] === 1'b1);
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_wide_wire[i] = res(i_wide_pad.oe[i], i_wide_pad.dout[i],
          i_wide_ext_en[i], i_wide_ext[i], i_wide_pad.pull[i], last_q[i]);
    end
    // Bench reset switch pulls bit three low through the external enable
    for (int i = 0; i < 4; i++) begin
      o_narrow_wire[i] = res(i_narrow_pad.oe[i], i_narrow_pad.dout[i],
          i_narrow_ext_en[i], i_narrow_ext[i], i_narrow_pad.pull[i],
          last_q[8+i]);
    end
  end
endmodule : iopr_board

// File: sim/tb_top.sv
// Self-checking bench for the port block with a board model on the pins.
// Assumes a short minimum reset pulse of 4 cycles to keep the run brief.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fuse = 1'b1;
  iopr_pkg::iopr_wide_ctl_type wctl = '0;
  iopr_pkg::iopr_narrow_ctl_type nctl = '0;
  iopr_pkg::iopr_alt_type alt = '0;
  logic [7:0] wext = 8'h00, wexten = 8'h00, wwire, win;
  logic [3:0] nx = 4'h0, nxen = 4'h0, nwire, nin;
  iopr_pkg::iopr_wide_pad_type wpad;
  iopr_pkg::iopr_narrow_pad_type npad;
  logic xrst;
  int err_total = 0, check_count = 0;
  localparam int PULSE = 4;
  always #2 clk = ~clk;
  iopr_top #(.MIN_PULSE_CYC(PULSE)) uut (.i_core_clk(clk), .i_sys_rst(rst),
    .i_reset_pin_disable_fuse(fuse), .i_wide_ctl(wctl),
    .i_narrow_ctl(nctl), .i_wide_alt(alt), .i_wide_pad(wwire),
    .i_narrow_pad(nwire), .o_wide_pad(wpad), .o_narrow_pad(npad),
    .o_wide_in(win), .o_narrow_in(nin), .o_ext_reset(xrst));
  iopr_board brd (.i_core_clk(clk), .i_wide_pad(wpad), .i_narrow_pad(npad),
    .i_wide_ext(wext), .i_wide_ext_en(wexten), .i_narrow_ext(nx),
    .i_narrow_ext_en(nxen), .o_wide_wire(wwire), .o_narrow_wire(nwire));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic t_rst;
    @(posedge clk);
    fuse <= 1'b0;
    wctl <= {8'hff, 8'hff, 8'h00};
    nctl <= {4'hf, 4'hf, 4'h0};
    rst <= 1'b1;
    cyc(2);
    chk("wide oe", wpad.oe, 8'h00);
    chk("narrow oe", {4'h0, npad.oe}, 8'h00);
    chk("wide dout", wpad.dout, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("narrow oe out", {4'h0, npad.oe}, 8'h0f);
    chk("wide oe out", wpad.oe, 8'hff);
    $display("test reset done");
  endtask : t_rst
  task automatic t_drive;
    @(posedge clk);
    fuse <= 1'b0;
    wctl <= {8'h0f, 8'ha5, 8'hf0};
    nctl <= {4'hc, 4'h8, 4'h3};
    cyc(2);
    chk("wide oe", wpad.oe, 8'h0f);
    chk("wide dout", wpad.dout & wpad.oe, 8'h05);
    chk("wide pull", wpad.pull, 8'hf0);
    chk("narrow oe", {4'h0, npad.oe}, 8'h0c);
    chk("narrow dout", {4'h0, npad.dout}, 8'h08);
    chk("narrow pull", {4'h0, npad.pull}, 8'h03);
    chk("weak", {7'h0, npad.weak3}, 8'h01);
    cyc(1);
    chk("wide in", win, 8'hf5);
    chk("narrow in", {4'h0, nin}, 8'h0b);
    @(posedge clk);
    fuse <= 1'b1;
    cyc(2);
    chk("fuse oe", {4'h0, npad.oe}, 8'h04);
    chk("fuse dout", {4'h0, npad.dout}, 8'h00);
    chk("fuse pull", {4'h0, npad.pull}, 8'h0b);
    chk("fuse weak", {7'h0, npad.weak3}, 8'h00);
    $display("test drive done");
  endtask : t_drive
  task automatic t_alt;
    @(posedge clk);
    // Port control differs from the override on every taken-over bit except bit one
    wctl <= {8'hc3, 8'he7, 8'h00};
    alt <= {8'h3e, 8'hff, 8'h1a};
    cyc(2);
    chk("alt oe", wpad.oe, 8'hff);
    chk("alt dout", wpad.dout & wpad.oe, 8'hdb);
    @(posedge clk);
    alt <= '0;
    $display("test alt done");
  endtask : t_alt
  task automatic t_xrst;
    int n;
    @(posedge clk);
    fuse <= 1'b0;
    nctl <= '0;
    wctl <= {8'hff, 8'h00, 8'h00};
    nxen <= 4'h8;
    cyc(10);
    chk("freed pin", {7'h0, xrst}, 8'h00);
    @(posedge clk);
    fuse <= 1'b1;
    nxen <= 4'h0;
    cyc(2);
    // Low for three samples, one short of the minimum
    @(posedge clk);
    nxen <= 4'h8;
    repeat (3) @(posedge clk);
    nxen <= 4'h0;
    cyc(3);
    chk("short pulse", {7'h0, xrst}, 8'h00);
    @(posedge clk);
    nxen <= 4'h8;
    n = 0;
    while (xrst !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      $display("timeout waiting for pin reset");
      return;
    end
    chk("pulse len", 8'(n), 8'(PULSE));
    cyc(1);
    chk("rst held", {7'h0, xrst}, 8'h01);
    chk("rst wide oe", wpad.oe, 8'h00);
    chk("rst narrow oe", {4'h0, npad.oe}, 8'h00);
    @(posedge clk);
    nxen <= 4'h0;
    cyc(3);
    chk("released", {7'h0, xrst}, 8'h00);
    chk("wide back", wpad.oe, 8'hff);
    $display("test pin reset done");
  endtask : t_xrst
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_rst();
    t_drive();
    t_alt();
    t_xrst();
    final_report();
  end
endmodule : tb_top
